// file: logic/sagsd_core.sv
/*
 * Store and subtract execution core with an AHB-Lite register window.
 * An instruction word written to the instruction register executes at the
 * end of that write's data phase; stores leave on the store port one cycle
 * later. Assumes one AHB master and a data memory that always accepts.
 */
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps

module sagsd_core #(
    parameter int unsigned REG_CNT = 16
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             st_valid,
    output logic      [31:0] st_addr,
    output logic      [31:0] st_data,
    output logic      [3:0]  st_strb
);
    localparam int IDX_W = $clog2(REG_CNT);

    logic [31:0]      rf_a_q [REG_CNT];
    logic [31:0]      rf_b_q [REG_CNT];
    logic             ap_q;
    logic             ap_wr_q;
    logic [7:0]       ap_ofs_q;
    logic [4:0]       rf_index_q;
    logic [31:0]      addr_mode_q;
    logic [2:0]       stat_q;
    logic [15:0]      st_cnt_q;
    logic [31:0]      instr;
    logic             exec;
    sagsd_pkg::sagsd_cls_e cls;
    logic             side;
    logic             xside;
    logic [IDX_W-1:0] i1;
    logic [IDX_W-1:0] i2;
    logic [IDX_W-1:0] idst;
    logic [31:0]      scst;
    logic [31:0]      a_n;
    logic [31:0]      a_x;
    logic [31:0]      b_n;
    logic [31:0]      b_x;
    logic [39:0]      diff;
    logic [31:0]      lng_hi;
    logic [31:0]      lng_lo;
    logic             is_long;
    logic             legal;
    logic             cond;
    logic [2:0]       sz;
    logic [31:0]      agu_base;
    logic [31:0]      agu_off;
    logic [3:0]       agu_mode;
    logic             agu_circ;
    logic [31:0]      agu_addr;
    logic [31:0]      agu_new;
    logic [IDX_W-1:0] base_idx;
    logic             base_file;
    logic [31:0]      src_val;
    logic [3:0]       adm_pos;
    logic             wr_en;
    logic             wr_file;
    logic [IDX_W-1:0] wr_idx;
    logic [31:0]      wr_data;
    logic             wr_hi_en;
    logic             st_go;

    function automatic logic [31:0] sx32(input logic [4:0] v);
        return {{27{v[4]}}, v};
    endfunction

    function automatic logic [39:0] sx40(input logic [31:0] v);
        return {{8{v[31]}}, v};
    endfunction

    function automatic logic [39:0] zx40(input logic [31:0] v);
        return {8'h00, v};
    endfunction

    function automatic logic [31:0] rf_rd(input logic f, input logic [IDX_W-1:0] i);
        return f ? rf_b_q[i] : rf_a_q[i];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ap_q     <= 1'b0;
            ap_wr_q  <= 1'b0;
            ap_ofs_q <= 8'h00;
        end
        else if (hready)
        begin
            ap_q     <= hsel & htrans[1];
            ap_wr_q  <= hwrite;
            ap_ofs_q <= haddr[7:0];
        end
    end

    always_comb
    begin
        hrdata = sagsd_pkg::WORD_ZERO;
        if (ap_q && !ap_wr_q)
        begin
            unique case (ap_ofs_q)
                sagsd_pkg::OFS_RF_INDEX:  hrdata = {27'h0, rf_index_q};
                sagsd_pkg::OFS_RF_DATA:
                    hrdata = rf_rd(rf_index_q[sagsd_pkg::RFI_FILE_BIT], rf_index_q[IDX_W-1:0]);
                sagsd_pkg::OFS_ADDR_MODE: hrdata = addr_mode_q;
                sagsd_pkg::OFS_STATUS:    hrdata = {st_cnt_q, 13'h0, stat_q};
                sagsd_pkg::OFS_LAST_ADDR: hrdata = st_addr;
                sagsd_pkg::OFS_LAST_DATA: hrdata = st_data;
                default:                  hrdata = sagsd_pkg::WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rf_index_q  <= 5'h00;
            addr_mode_q <= sagsd_pkg::ADDR_MODE_RESET;
        end
        else if (ap_q && ap_wr_q)
        begin
            if (ap_ofs_q == sagsd_pkg::OFS_RF_INDEX)
                rf_index_q <= hwdata[4:0];
            if (ap_ofs_q == sagsd_pkg::OFS_ADDR_MODE)
                addr_mode_q <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decode: the instruction word is the write data of the instruction register

    assign exec  = ap_q & ap_wr_q & (ap_ofs_q == sagsd_pkg::OFS_INSTR);
    assign instr = hwdata;

    always_comb
    begin
        if (instr[3:2] == sagsd_pkg::TAG_ST_SHORT)
            cls = sagsd_pkg::CLS_STS;
        else if (instr[3:2] == sagsd_pkg::TAG_ST_LONG)
            cls = sagsd_pkg::CLS_STL;
        else if (instr[4:2] == sagsd_pkg::TAG_L)
            cls = sagsd_pkg::CLS_L;
        else if (instr[5:2] == sagsd_pkg::TAG_S)
            cls = sagsd_pkg::CLS_S;
        else if (instr[6:2] == sagsd_pkg::TAG_D)
            cls = sagsd_pkg::CLS_D;
        else
            cls = sagsd_pkg::CLS_NONE;
    end

    assign side  = instr[sagsd_pkg::F_S];
    assign xside = instr[sagsd_pkg::F_X] ? ~side : side;
    assign i1    = instr[sagsd_pkg::F_SRC1 +: IDX_W];
    assign i2    = instr[sagsd_pkg::F_SRC2 +: IDX_W];
    assign idst  = instr[sagsd_pkg::F_DST +: IDX_W];
    assign scst  = sx32(instr[sagsd_pkg::F_SRC1 +: 5]);
    assign a_n   = rf_rd(side, i1);
    assign a_x   = rf_rd(xside, i1);
    assign b_n   = rf_rd(side, i2);
    assign b_x   = rf_rd(xside, i2);
    assign lng_hi = rf_rd(side, i2 | IDX_W'(1));
    assign lng_lo = rf_rd(side, i2 & ~IDX_W'(1));

    // predicate: 0 always (never with z), 1..3 test B0..B2, 4..5 test A1..A2, 6..7 never
    always_comb
    begin
        logic [31:0] pv;
        pv   = sagsd_pkg::WORD_ZERO;
        cond = 1'b1;
        unique case (instr[sagsd_pkg::F_CREG +: 3])
            3'h0: cond = ~instr[sagsd_pkg::F_Z];
            3'h1: pv = rf_b_q[0];
            3'h2: pv = rf_b_q[1];
            3'h3: pv = rf_b_q[2];
            3'h4: pv = rf_a_q[1];
            3'h5: pv = rf_a_q[2];
            default: cond = 1'b0;
        endcase
        if (instr[sagsd_pkg::F_CREG +: 3] != 3'h0)
            cond = cond & (instr[sagsd_pkg::F_Z] ? (pv == 32'h0) : (pv != 32'h0));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // subtract datapath, 40 bits wide so long results share it

    always_comb
    begin
        diff    = 40'h00_0000_0000;
        is_long = 1'b0;
        legal   = 1'b1;
        unique case (cls)
            sagsd_pkg::CLS_L:
                unique case (instr[sagsd_pkg::F_LOP +: 7])
                    sagsd_pkg::OP_L_SUB_X2:  diff = sx40(a_n) - sx40(b_x);
                    sagsd_pkg::OP_L_SUB_X1:  diff = sx40(a_x) - sx40(b_n);
                    sagsd_pkg::OP_L_USUB_X2:
                    begin
                        diff    = zx40(a_n) - zx40(b_x);
                        is_long = 1'b1;
                    end
                    sagsd_pkg::OP_L_CSUB:    diff = sx40(scst) - sx40(b_x);
                    sagsd_pkg::OP_L_SUBL_X2, sagsd_pkg::OP_L_SUBL_X1:
                    begin
                        diff    = instr[sagsd_pkg::F_LOP + 4] ? sx40(a_x) - sx40(b_n)
                                                             : sx40(a_n) - sx40(b_x);
                        is_long = 1'b1;
                    end
                    sagsd_pkg::OP_L_USUB_X1:
                    begin
                        diff    = zx40(a_x) - zx40(b_n);
                        is_long = 1'b1;
                    end
                    sagsd_pkg::OP_L_CSUBL:
                    begin
                        // long source is the even/odd pair named by src2
                        diff    = sx40(scst) - {lng_hi[7:0], lng_lo};
                        is_long = 1'b1;
                    end
                    default: legal = 1'b0;
                endcase
            sagsd_pkg::CLS_S:
                unique case (instr[sagsd_pkg::F_SOP +: 6])
                    sagsd_pkg::OP_S_SUB:  diff = sx40(a_n) - sx40(b_x);
                    sagsd_pkg::OP_S_CSUB: diff = sx40(scst) - sx40(b_x);
                    default: legal = 1'b0;
                endcase
            sagsd_pkg::CLS_D:
                unique case (instr[sagsd_pkg::F_DOP +: 6])
                    sagsd_pkg::OP_D_SUB:  diff = sx40(b_n) - sx40(a_n);
                    sagsd_pkg::OP_D_USUB:
                        diff = sx40(b_n) - {35'h0, instr[sagsd_pkg::F_SRC1 +: 5]};
                    default: legal = 1'b0;
                endcase
            sagsd_pkg::CLS_STS:
                // post-modify needs the update bit
                legal = (sz != 3'h0) & ~(instr[sagsd_pkg::F_MODE + sagsd_pkg::MODE_POST]
                                       & ~instr[sagsd_pkg::F_MODE + sagsd_pkg::MODE_WB]);
            sagsd_pkg::CLS_STL: legal = (sz != 3'h0);
            default: legal = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // store address generation

    // one-hot access size: bit0 byte, bit1 half, bit2 word; zero for any other ldst code
    always_comb
    begin
        unique case (instr[sagsd_pkg::F_LDST +: 3])
            sagsd_pkg::LDST_BYTE: sz = 3'h1;
            sagsd_pkg::LDST_HALF: sz = 3'h2;
            sagsd_pkg::LDST_WORD: sz = 3'h4;
            default:              sz = 3'h0;
        endcase
    end

    always_comb
    begin
        base_file = instr[sagsd_pkg::F_Y];
        base_idx  = instr[sagsd_pkg::F_SRC2 +: IDX_W];
        adm_pos   = {base_file, 1'b0, base_idx[1:0]};
        agu_mode  = instr[sagsd_pkg::F_MODE +: 4];
        agu_off   = agu_mode[sagsd_pkg::MODE_REG] ? rf_rd(base_file, i1)
                                                  : {27'h0, instr[sagsd_pkg::F_SRC1 +: 5]};
        // only registers four to seven of each file may wrap
        agu_circ  = (base_idx[IDX_W-1:2] == 2'(1))
                  & (addr_mode_q[{adm_pos[3], 3'h0} + {adm_pos[1:0], 1'b0} +: 2]
                     == sagsd_pkg::ADM_CIRCULAR);
        if (cls == sagsd_pkg::CLS_STL)
        begin
            base_file = 1'b1;
            base_idx  = instr[sagsd_pkg::F_Y] ? sagsd_pkg::BASE_PTR_FIFTEEN
                                              : sagsd_pkg::BASE_PTR_FOURTEEN;
            agu_mode  = sagsd_pkg::MODE_LONG;
            agu_off   = {17'h0, instr[sagsd_pkg::F_UC15 +: 15]};
            agu_circ  = 1'b0;
        end
        agu_base = rf_rd(base_file, base_idx);
    end

    sagsd_agu u_agu (
        .base      (agu_base),
        .offset    (agu_off),
        .shift     ({sz[2], sz[1]}),
        .mode      (agu_mode),
        .circ      (agu_circ),
        .block_log (addr_mode_q[sagsd_pkg::ADM_BK_LSB +: 5]),
        .mem_addr  (agu_addr),
        .new_base  (agu_new)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // commit: register writes and the store port

    assign st_go   = exec & legal & cond & ((cls == sagsd_pkg::CLS_STS)
                                          | (cls == sagsd_pkg::CLS_STL));
    assign src_val = rf_rd(instr[sagsd_pkg::F_S], instr[sagsd_pkg::F_DST +: IDX_W]);

    always_comb
    begin
        wr_en    = 1'b0;
        wr_hi_en = 1'b0;
        wr_file  = side;
        wr_idx   = idst;
        wr_data  = diff[31:0];
        if (exec && legal && cond)
        begin
            if (cls == sagsd_pkg::CLS_STS)
            begin
                wr_en   = instr[sagsd_pkg::F_MODE + sagsd_pkg::MODE_WB];
                wr_file = base_file;
                wr_idx  = base_idx;
                wr_data = agu_new;
            end
            else if (cls != sagsd_pkg::CLS_STL)
            begin
                wr_en    = 1'b1;
                wr_hi_en = is_long;
                if (is_long)
                    wr_idx = idst & ~IDX_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < REG_CNT; i++)
            begin
                rf_a_q[i] <= sagsd_pkg::WORD_ZERO;
                rf_b_q[i] <= sagsd_pkg::WORD_ZERO;
            end
        end
        else
        begin
            if (ap_q && ap_wr_q && ap_ofs_q == sagsd_pkg::OFS_RF_DATA)
            begin
                if (rf_index_q[sagsd_pkg::RFI_FILE_BIT])
                    rf_b_q[rf_index_q[IDX_W-1:0]] <= hwdata;
                else
                    rf_a_q[rf_index_q[IDX_W-1:0]] <= hwdata;
            end
            if (wr_en)
            begin
                if (wr_file)
                    rf_b_q[wr_idx] <= wr_data;
                else
                    rf_a_q[wr_idx] <= wr_data;
            end
            if (wr_hi_en)
            begin
                if (wr_file)
                    rf_b_q[wr_idx | IDX_W'(1)] <= {24'h0, diff[39:32]};
                else
                    rf_a_q[wr_idx | IDX_W'(1)] <= {24'h0, diff[39:32]};
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_valid <= 1'b0;
            st_addr  <= sagsd_pkg::WORD_ZERO;
            st_data  <= sagsd_pkg::WORD_ZERO;
            st_strb  <= 4'h0;
            st_cnt_q <= 16'h0000;
        end
        else
        begin
            st_valid <= st_go;
            if (st_go)
            begin
                st_addr  <= agu_addr;
                st_cnt_q <= st_cnt_q + 16'h0001;
                // narrow data is replicated so it sits on its own lanes
                if (sz[0])
                begin
                    st_data <= {4{src_val[7:0]}};
                    st_strb <= 4'h1 << agu_addr[1:0];
                end
                else if (sz[1])
                begin
                    st_data <= {2{src_val[15:0]}};
                    st_strb <= agu_addr[1] ? 4'hC : 4'h3;
                end
                else
                begin
                    st_data <= src_val;
                    st_strb <= 4'hF;
                end
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            stat_q <= 3'h0;
        else if (exec)
        begin
            stat_q[sagsd_pkg::STAT_EXEC_BIT] <= legal & cond;
            stat_q[sagsd_pkg::STAT_SKIP_BIT] <= legal & ~cond;
            stat_q[sagsd_pkg::STAT_ILL_BIT]  <= ~legal;
        end
    end

endmodule

// file: logic/sagsd_pkg.sv
/*
 * Constants for the store address generator and subtract decoder: register
 * offsets on the AHB-Lite window, instruction field positions, decode tags,
 * opfields, mode bits and reset values.
 * Assumes nothing beyond a SystemVerilog compiler; every user names
 * sagsd_pkg::name explicitly.
 */
package sagsd_pkg;

    // register offsets, byte addresses of aligned words
    localparam logic [7:0]  OFS_INSTR     = 8'h00;
    localparam logic [7:0]  OFS_RF_INDEX  = 8'h04;
    localparam logic [7:0]  OFS_RF_DATA   = 8'h08;
    localparam logic [7:0]  OFS_ADDR_MODE = 8'h0C;
    localparam logic [7:0]  OFS_STATUS    = 8'h10;
    localparam logic [7:0]  OFS_LAST_ADDR = 8'h14;
    localparam logic [7:0]  OFS_LAST_DATA = 8'h18;

    localparam logic [31:0] ADDR_MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
    localparam int          ADM_B_LSB       = 8;
    localparam int          ADM_BK_LSB      = 16;
    localparam logic [1:0]  ADM_CIRCULAR    = 2'h1;
    localparam int          RFI_FILE_BIT    = 4;
    localparam int          STAT_EXEC_BIT   = 0;
    localparam int          STAT_SKIP_BIT   = 1;
    localparam int          STAT_ILL_BIT    = 2;
    localparam int          STAT_CNT_LSB    = 16;

    // instruction field positions
    localparam int F_CREG = 29;
    localparam int F_Z    = 28;
    localparam int F_DST  = 23;
    localparam int F_SRC2 = 18;
    localparam int F_SRC1 = 13;
    localparam int F_X    = 12;
    localparam int F_MODE = 9;
    localparam int F_UC15 = 8;
    localparam int F_Y    = 7;
    localparam int F_LDST = 4;
    localparam int F_LOP  = 5;
    localparam int F_SOP  = 6;
    localparam int F_DOP  = 7;
    localparam int F_S    = 1;

    // class tags in the low bits
    localparam logic [1:0] TAG_ST_SHORT = 2'h1;
    localparam logic [1:0] TAG_ST_LONG  = 2'h3;
    localparam logic [2:0] TAG_L        = 3'h6;
    localparam logic [3:0] TAG_S        = 4'h8;
    localparam logic [4:0] TAG_D        = 5'h10;

    localparam logic [2:0] LDST_BYTE = 3'h3;
    localparam logic [2:0] LDST_HALF = 3'h5;
    localparam logic [2:0] LDST_WORD = 3'h7;

    localparam int MODE_WB   = 3;
    localparam int MODE_REG  = 2;
    localparam int MODE_POST = 1;
    localparam int MODE_ADD  = 0;
    localparam logic [3:0] MODE_LONG = 4'h1;

    localparam logic [3:0] BASE_PTR_FOURTEEN = 4'hE;
    localparam logic [3:0] BASE_PTR_FIFTEEN  = 4'hF;

    localparam logic [6:0] OP_L_SUB_X2  = 7'h07;
    localparam logic [6:0] OP_L_SUB_X1  = 7'h17;
    localparam logic [6:0] OP_L_SUBL_X2 = 7'h27;
    localparam logic [6:0] OP_L_SUBL_X1 = 7'h37;
    localparam logic [6:0] OP_L_USUB_X2 = 7'h2F;
    localparam logic [6:0] OP_L_USUB_X1 = 7'h3F;
    localparam logic [6:0] OP_L_CSUB    = 7'h06;
    localparam logic [6:0] OP_L_CSUBL   = 7'h24;
    localparam logic [5:0] OP_S_SUB     = 6'h17;
    localparam logic [5:0] OP_S_CSUB    = 6'h16;
    localparam logic [5:0] OP_D_SUB     = 6'h11;
    localparam logic [5:0] OP_D_USUB    = 6'h13;

    typedef enum logic [2:0] {
        CLS_NONE = 3'h0,
        CLS_L    = 3'h1,
        CLS_S    = 3'h3,
        CLS_D    = 3'h2,
        CLS_STS  = 3'h6,
        CLS_STL  = 3'h7
    } sagsd_cls_e;

endpackage

// file: logic/sagsd_agu.sv
/*
 * Address generator: scales the offset, adds or subtracts it, wraps it in a
 * circular block when asked, and picks pre or post address.
 * Assumes the caller qualifies the mode and the circular enable.
 */
`timescale 1ns/1ps
module sagsd_agu
(
    input  wire logic [31:0] base,
    input  wire logic [31:0] offset,
    input  wire logic [1:0]  shift,
    input  wire logic [3:0]  mode,
    input  wire logic        circ,
    input  wire logic [4:0]  block_log,
    output logic      [31:0] mem_addr,
    output logic      [31:0] new_base
);
    logic [31:0] scaled;
    logic [31:0] linear;
    logic [31:0] mask;

    always_comb
    begin
        scaled = offset << shift;
        linear = mode[sagsd_pkg::MODE_ADD] ? base + scaled : base - scaled;
        // block of 2^(n+1) bytes; the upper bits of the base never move
        mask   = (32'h0000_0002 << block_log) - 32'h0000_0001;
        new_base = circ ? ((base & ~mask) | (linear & mask)) : linear;
        // post forms send the untouched base out
        mem_addr = mode[sagsd_pkg::MODE_POST] ? base : new_base;
    end

endmodule

// file: verif/sagsd_properties.sv
/* port checker for the store and subtract core
 * assumes one clock and the core's zero wait state bus */
`timescale 1ns/1ps
module sagsd_properties
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        st_valid,
    input wire logic [31:0] st_addr,
    input wire logic [31:0] st_data,
    input wire logic [3:0]  st_strb
);
    logic rd_q;
    logic ex_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // high during the data phase of a read, or of an instruction write
    always_ff @(posedge sys_clk)
    begin
        rd_q <= rst_n && hsel && htrans[1] && hready && !hwrite;
        ex_q <= rst_n && hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
    end
    //////////////////////////////
    ready_high_a: assert property (hreadyout && !hresp) else $error("bus not ready");
    read_idle_a: assert property (!rd_q |-> hrdata == 32'h0) else $error("stray read data");
    store_pulse_a: assert property (st_valid |=> !st_valid || $past(ex_q))
        else $error("store strobe too long");
    store_cause_a: assert property (st_valid |-> $past(ex_q))
        else $error("store without instruction");
    byte_repl_a: assert property (st_valid && $onehot(st_strb) |->
        st_data == {4{st_data[7:0]}}) else $error("byte lanes differ");
    half_repl_a: assert property (st_valid && (st_strb == 4'h3 || st_strb == 4'hC) |->
        st_data[31:16] == st_data[15:0]) else $error("half lanes differ");
    lane_pick_a: assert property (st_valid |-> st_strb == 4'hF ||
        st_strb == (4'h1 << st_addr[1:0]) || st_strb == (st_addr[1] ? 4'hC : 4'h3))
        else $error("lane enable mismatch");
    store_hold_a: assert property (!st_valid |-> $stable(st_addr) && $stable(st_data))
        else $error("store port moved");
endmodule
bind sagsd_core sagsd_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .st_valid(st_valid), .st_addr(st_addr),
    .st_data(st_data), .st_strb(st_strb));

// file: verif/sagsd_mem.sv
/* data memory model on the store port
 * assumes single-cycle store strobes; it never stalls the core */
`timescale 1ns/1ps
module sagsd_mem
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        st_valid,
    input wire logic [31:0] st_addr,
    input wire logic [31:0] st_data,
    input wire logic [3:0]  st_strb,
    output logic     [31:0] m_addr,
    output logic     [31:0] m_data,
    output logic     [3:0]  m_strb,
    output logic     [15:0] m_cnt
);
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            m_cnt <= 16'h0000;
        else if (st_valid)
        begin
            m_addr <= st_addr;
            m_data <= st_data;
            m_strb <= st_strb;
            m_cnt  <= m_cnt + 16'h0001;
        end
    end
endmodule

// file: verif/testbench.sv
/* self-checking bench for the store and subtract core
 * assumes a zero wait state AHB-Lite slave and the memory model */
`timescale 1ns/1ps
module testbench;
    logic        sys_clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        st_valid;
    logic [31:0] st_addr;
    logic [31:0] st_data;
    logic [3:0]  st_strb;
    logic [31:0] m_addr;
    logic [31:0] m_data;
    logic [3:0]  m_strb;
    logic [15:0] m_cnt;
    logic [31:0] rd;
    int          n_fail;
    int          comparisons;
    sagsd_core u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .st_valid(st_valid),
        .st_addr(st_addr), .st_data(st_data), .st_strb(st_strb));
    sagsd_mem u_mem (.sys_clk(sys_clk), .rst_n(rst_n), .st_valid(st_valid), .st_addr(st_addr),
        .st_data(st_data), .st_strb(st_strb), .m_addr(m_addr), .m_data(m_data),
        .m_strb(m_strb), .m_cnt(m_cnt));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    //////////////////////////////
    task automatic summarize;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                n_fail++;
                summarize();
            end
            @(posedge sys_clk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic rf(input logic w, input logic [4:0] r, input logic [31:0] v);
        bus(1'b1, sagsd_pkg::OFS_RF_INDEX, {27'h0, r});
        bus(w, sagsd_pkg::OFS_RF_DATA, v);
        if (!w)
            chk("register", v, rd);
    endtask
    // the store leaves one cycle after the instruction write commits
    task automatic exec(input logic [31:0] ins);
        bus(1'b1, sagsd_pkg::OFS_INSTR, ins);
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic st_chk(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        chk("st_addr", a, m_addr);
        chk("st_data", d, m_data);
        chk("st_strb", {28'h0, s}, {28'h0, m_strb});
    endtask
    function automatic logic [31:0] ins(input logic [4:0] a, input logic [4:0] b,
        input logic [4:0] c, input logic [12:0] lo);
        return {4'h0, a, b, c, lo};
    endfunction
    //////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        n_fail = 0;
        comparisons = 0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, sagsd_pkg::OFS_ADDR_MODE, 32'h0);
        chk("addr_mode", sagsd_pkg::ADDR_MODE_RESET, rd);
        bus(1'b0, 8'h1C, 32'h0);
        chk("unmapped", 32'h0, rd);
        rf(1'b1, 5'h02, 32'h0000_0100);
        rf(1'b1, 5'h05, 32'h1234_5678);
        rf(1'b1, 5'h13, 32'h0000_0200);
        rf(1'b1, 5'h16, 32'hCAFE_1234);
        rf(1'b1, 5'h1E, 32'h0000_1000);
        rf(1'b1, 5'h1F, 32'h0000_2000);
        exec(ins(5'h05, 5'h02, 5'h03, 13'h0274));
        st_chk(32'h0000_010C, 32'h1234_5678, 4'hF);
        exec(ins(5'h05, 5'h02, 5'h05, 13'h1034));
        st_chk(32'h0000_00FB, 32'h7878_7878, 4'h8);
        rf(1'b0, 5'h02, 32'h0000_00FB);
        exec(ins(5'h16, 5'h03, 5'h02, 13'h16D6));
        st_chk(32'h0000_0200, 32'h1234_1234, 4'h3);
        rf(1'b0, 5'h13, 32'h0000_0204);
        exec(32'h0280_283C);
        st_chk(32'h0000_1028, 32'h7878_7878, 4'h1);
        exec(32'h0280_03FC);
        st_chk(32'h0000_200C, 32'h1234_5678, 4'hF);
        $display("test stores done");
        rf(1'b1, 5'h01, 32'h0000_325A);
        rf(1'b1, 5'h04, 32'hFFFF_FF12);
        exec(ins(5'h03, 5'h04, 5'h01, 13'h00F8));
        rf(1'b0, 5'h03, 32'h0000_3348);
        exec(ins(5'h07, 5'h04, 5'h01, 13'h05E0));
        rf(1'b0, 5'h07, 32'h0000_3348);
        exec(ins(5'h08, 5'h04, 5'h01, 13'h08C0));
        rf(1'b0, 5'h08, 32'hFFFF_CCB8);
        exec(ins(5'h09, 5'h04, 5'h02, 13'h09C0));
        rf(1'b0, 5'h09, 32'hFFFF_FF10);
        exec(ins(5'h0A, 5'h04, 5'h01, 13'h05F8));
        rf(1'b0, 5'h0A, 32'h0000_3348);
        rf(1'b0, 5'h0B, 32'h0000_00FF);
        $display("test subtract done");
        bus(1'b1, sagsd_pkg::OFS_ADDR_MODE, 32'h0003_0001);
        exec(ins(5'h05, 5'h04, 5'h0E, 13'h0234));
        st_chk(32'hFFFF_FF10, 32'h7878_7878, 4'h1);
        exec(ins(5'h05, 5'h02, 5'h03, 13'h0274) | 32'h9000_0000);
        chk("store count", 32'h0000_0006, {16'h0, m_cnt});
        bus(1'b0, sagsd_pkg::OFS_STATUS, 32'h0);
        chk("status", 32'h0006_0002, rd);
        $display("test predicate done");
        summarize();
    end
endmodule
